// ---- dv/octal_dac_serial_command_logic_tb.sv ----
// self-checking bench for the octal converter serial command logic
// assumes the host model frames words; expectations are kept in rows
`timescale 1ns/1ns
module octal_dac_serial_command_logic_tb;
  typedef struct packed {
    logic [15:0] w;                         // serial word
    logic [79:0] code;                      // expected output codes
    logic [7:0]  pwr;                       // expected powered flags
  } odsc_row_t;

  // ==========================================================
  // signals
  logic        clk;                         // 250 MHz clock
  logic        sys_rst;                     // sync reset, high
  logic        sclk;                        // serial clock
  logic        sdin;                        // serial data
  logic        cs_n;                        // chip select, low
  logic        load_n;                      // load pin, low
  logic        hclr_n;                      // clear pin, low
  logic        ce;                          // clock enable
  logic        sdout;                       // daisy-chain out
  logic [79:0] code;                        // output codes
  logic [7:0]  pwr;                         // powered flags
  logic        done;                        // word executed pulse
  int          err_count;                   // mismatches
  int          samples_checked;             // comparisons made
  int          done_cnt;                    // executed words seen
  int          n0;                          // done count before a frame
  odsc_row_t   rows [16];                   // ordinary cases

  initial clk = 1'b0;
  always #2 clk = ~clk;

  odsc_top DUT (
    .I_CLK           (clk),
    .I_SYS_RST       (sys_rst),
    .I_CE            (ce),
    .I_SCLK          (sclk),
    .I_SDIN          (sdin),
    .I_CS_N          (cs_n),
    .I_OUTPUT_LOAD_N (load_n),
    .I_HARD_CLEAR_N  (hclr_n),
    .O_SDOUT         (sdout),
    .O_CODE          (code),
    .O_POWERED       (pwr),
    .O_WORD_DONE     (done)
  );

  odsc_host #(.HALF(6)) host (
    .i_clk   (clk),
    .i_sdout (sdout),
    .o_sclk  (sclk),
    .o_sdin  (sdin),
    .o_cs_n  (cs_n)
  );

  // count executed words; a pulse is one cycle wide
  always @(posedge clk)
    if (done === 1'b1)
      done_cnt++;

  // ==========================================================
  // helpers
  function automatic odsc_row_t mk(input logic [3:0] c,
    input logic [9:0] d, input logic [79:0] e, input logic [7:0] p);
    return {c, d, 2'b00, e, p};
  endfunction

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one frame, then let decode and update land before looking
  task automatic frame(input logic [31:0] w, input int n, input int nd);
    n0 = done_cnt;
    host.send(w, n);
    repeat (12) @(posedge clk);
    check(80'(done_cnt - n0), 80'(nd));
  endtask

  task automatic report_and_stop();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far above the few thousand cycles the tests need
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    load_n = 1'b1;
    hclr_n = 1'b1;
    ce = 1'b1;
    err_count = 0;
    samples_checked = 0;
    done_cnt = 0;
    // single input loads, ch1 code 101 up to ch8 code 108
    for (int i = 0; i < 8; i++)
      rows[i] = mk(4'(4'h2 + i), 10'(10'h101 + i), 80'h0, 8'h00);
    rows[8]  = mk(4'hE, 10'h204, {10'h108, {6{10'h000}}, 10'h101}, 8'h81);
    rows[9]  = mk(4'hA, 10'h001, {10'h108, {3{10'h0}}, {4{10'h001}}}, 8'h8F);
    rows[10] = mk(4'hD, 10'h0AA, {10'h108, {3{10'h0}}, {4{10'h001}}}, 8'h8F);
    rows[11] = mk(4'hE, 10'h1F8, {10'h108, {6{10'h0AA}}, 10'h001}, 8'hFF);
    rows[12] = mk(4'hB, 10'h200, {{4{10'h200}}, {3{10'h0AA}}, 10'h001}, 8'hFF);
    rows[13] = mk(4'hC, 10'h3C3, {8{10'h3C3}}, 8'hFF);
    rows[14] = mk(4'h0, 10'h3FF, {8{10'h3C3}}, 8'hFF);
    rows[15] = mk(4'h1, 10'h155, 80'h0, 8'h00);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    check(code, 80'h0);
    check(80'({pwr, sdout, done}), 80'h0);
    foreach (rows[r])
    begin
      frame({16'h0, rows[r].w}, 16, 1);
      check(code, rows[r].code);
      check(80'(pwr), 80'(rows[r].pwr));
    end
    frame({16'h0, 4'hC, 10'h155, 2'b00}, 15, 0);
    check(code, 80'h0);
    frame({12'h0, 4'h5, 4'hC, 10'h2AA, 2'b00}, 20, 1);
    check(code, {8{10'h2AA}});
    frame({16'h0, 4'hD, 10'h111, 2'b00}, 16, 1);
    check(code, {8{10'h2AA}});
    @(posedge clk);
    load_n <= 1'b0;
    repeat (4) @(posedge clk);
    load_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(code, {8{10'h111}});
    frame({16'hA554, 16'h0000}, 32, 1);
    check(80'(host.cap_q[15:0]), 80'hA554);
    check(code, {8{10'h111}});
    // clock enable low freezes the block: a whole frame goes unseen
    ce <= 1'b0;
    frame({16'h0, 4'hC, 10'h0AB, 2'b00}, 16, 0);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    check(code, {8{10'h111}});
    n0 = done_cnt;
    fork
      host.send({16'h0, 4'hC, 10'h0F0, 2'b00}, 16);
      begin
        repeat (100) @(posedge clk);
        hclr_n <= 1'b0;
        repeat (4) @(posedge clk);
        hclr_n <= 1'b1;
      end
    join
    repeat (12) @(posedge clk);
    check(80'(done_cnt - n0), 80'h0);
    check(code, 80'h0);
    check(80'(pwr), 80'h0);
    frame({16'h0, 4'hC, 10'h3FF, 2'b00}, 16, 1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(code, 80'h0);
    check(80'({pwr, sdout, done}), 80'h0);
    report_and_stop();
  end
endmodule // octal_dac_serial_command_logic_tb

// ---- dv/odsc_host.sv ----
// serial master model that frames words into the converter's serial port
// assumes the bench calls send from one process, one frame at a time
`timescale 1ns/1ns
module odsc_host #(
  parameter int HALF = 6                    // sclk half period, in cycles
) (
  input  wire logic i_clk,                  // system clock
  input  wire logic i_sdout,                // daisy-chain data coming back
  output logic      o_sclk,                 // serial clock, idles low
  output logic      o_sdin,                 // serial data
  output logic      o_cs_n                  // chip select, active low
);
  // ==========================================================
  // state
  logic [31:0] cap_q;                       // daisy data seen after each fall

  // idle pins before the first frame
  initial
  begin
    o_sclk = 1'b0;
    o_sdin = 1'b0;
    o_cs_n = 1'b1;
  end

  // ==========================================================
  // frame task
  // sends the low n bits of w, top bit first; n other than 16 is
  // how the bench asks for a short or an over-long frame
  task automatic send(input logic [31:0] w, input int n);
    @(posedge i_clk);
    cap_q  <= '0;
    o_cs_n <= 1'b0;
    // keep cs low a while before the first fall
    repeat (HALF) @(posedge i_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdin <= w[i];
      o_sclk <= 1'b1;
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (HALF) @(posedge i_clk);
      // chained bit moves on the fall; take it once it settled
      cap_q  <= {cap_q[30:0], i_sdout};
    end
    // deselect; data line no longer holds the last bit
    o_cs_n <= 1'b1;
    o_sdin <= ~o_sdin;
    // keep cs high long enough between frames
    repeat (HALF) @(posedge i_clk);
  endtask
endmodule // odsc_host

// ---- rtl/odsc_chreg.sv ----
// one channel's input register and output-code register pair
// assumes loads arrive as single-cycle strobes from the decoder
`timescale 1ns/1ns
module odsc_chreg (
  input  wire logic       i_clk,                    // system clock
  input  wire logic       i_clr,                    // clear both stages
  input  wire logic       i_ce,                     // clock enable
  input  wire logic       i_ld_in,                  // load input stage
  input  wire logic       i_ld_out,                 // load output with code
  input  wire logic       i_xfer,                   // copy input to output
  input  wire logic       i_transp,                 // output follows input
  input  wire logic [9:0] i_code,                   // code from the word
  output logic      [9:0] o_in,                     // input register
  output logic      [9:0] o_out                     // output-code register
);
  // ===========================================================
  // input stage
  always_ff @(posedge i_clk)
  begin
    if (i_clr)
      o_in <= odsc_pkg::CODE_RST;
    else if (i_ce && i_ld_in)
      o_in <= i_code;
  end
  // output stage; write-through code wins over transfer and transparency, which copy the input
  always_ff @(posedge i_clk)
  begin
    if (i_clr)
      o_out <= odsc_pkg::CODE_RST;
    else if (i_ce)
    begin
      if (i_ld_out)
        o_out <= i_code;
      else if (i_xfer || i_transp)
        o_out <= o_in;
    end
  end
endmodule // odsc_chreg

// ---- rtl/odsc_pkg.sv ----
// constants of the octal converter serial command logic
// assumes a single system clock domain; serial pins are sampled inside it
package odsc_pkg;
  // ===========================================================
  // frame layout
  localparam int unsigned WORD_W     = 16;          // bits per frame
  localparam int unsigned CODE_W     = 10;          // converter code width
  localparam int unsigned CMD_W      = 4;           // command field width
  localparam int unsigned NUM_CH     = 8;           // channel count
  localparam int unsigned CMD_MSB    = 15;          // command field top bit
  localparam int unsigned CMD_LSB    = 12;          // command field low bit
  localparam int unsigned CODE_MSB   = 11;          // code field top bit
  localparam int unsigned CODE_LSB   = 2;           // code field low bit
  localparam int unsigned MASK_MSB   = 11;          // transfer mask top bit
  localparam int unsigned MASK_LSB   = 4;           // transfer mask low bit
  localparam int unsigned CNT_W      = 5;           // bit counter width
  localparam logic [4:0]  CNT_FULL   = 5'h10;       // count of a whole word
  localparam int unsigned FULL_SCALE = 1024;        // codes per reference
  // ===========================================================
  // reset values
  localparam logic [9:0]  CODE_RST   = 10'h000;     // code after reset
  localparam logic [15:0] SHIFT_RST  = 16'h0000;    // shifter after reset
  localparam logic [7:0]  PWR_RST    = 8'h00;       // all channels powered down
  // pin order sclk, sdin, cs, load, clear; idle levels avoid a false edge
  localparam logic [4:0]  PIN_RST    = 5'h07;       // synchroniser after reset
  // ===========================================================
  // commands
  typedef enum logic [3:0] {
    CMD_NOP    = 4'h0,  // no_action_word
    CMD_RESET  = 4'h1,  // soft clear
    CMD_IN1    = 4'h2,  // first of the single input loads
    CMD_IN8    = 4'h9,  // last of the single input loads
    CMD_WT_LO  = 4'hA,  // write through channels 1..4
    CMD_WT_HI  = 4'hB,  // write through channels 5..8
    CMD_WT_ALL = 4'hC,  // write through all channels
    CMD_IN_ALL = 4'hD,  // load all input registers
    CMD_XFER   = 4'hE,  // masked transfer input to output
    CMD_PWR    = 4'hF   // power commands
  } odsc_cmd_t;
endpackage : odsc_pkg

// ---- rtl/odsc_sync.sv ----
// two flip-flop synchroniser for a bus of asynchronous pins
// assumes all bits are independent levels
`timescale 1ns/1ns
module odsc_sync #(
  parameter int unsigned W     = 1,                 // bits to pass
  parameter logic [W-1:0] INIT = '0                 // value under reset
) (
  input  wire logic         i_clk,                  // system clock
  input  wire logic         i_rst,                  // sync reset, high
  input  wire logic         i_ce,                   // clock enable
  input  wire logic [W-1:0] i_d,                    // asynchronous in
  output logic      [W-1:0] o_q                     // synchronised out
);
  // ===========================================================
  // stages
  logic [W-1:0] meta_q;                             // first stage only
  // first stage feeds nothing but the second
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_q <= INIT;
      o_q    <= INIT;
    end
    else if (i_ce)
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule // odsc_sync

// ---- rtl/odsc_top.sv ----
// serial command logic of an eight-channel 10-bit converter
// assumes serial pins and load/clear pins are asynchronous to I_CLK
`timescale 1ns/1ns
module odsc_top (
  input  wire logic        I_CLK,                   // 250 MHz system clock
  input  wire logic        I_SYS_RST,               // sync reset, high
  input  wire logic        I_CE,                    // clock enable
  input  wire logic        I_SCLK,                  // serial clock pin
  input  wire logic        I_SDIN,                  // serial data pin
  input  wire logic        I_CS_N,                  // chip select, low
  input  wire logic        I_OUTPUT_LOAD_N,         // load pin, low
  input  wire logic        I_HARD_CLEAR_N,          // clear pin, low
  output logic             O_SDOUT,                 // daisy-chain out
  output logic [79:0]      O_CODE,                  // output codes, ch1 low
  output logic [7:0]       O_POWERED,               // channel powered up
  output logic             O_WORD_DONE              // word executed pulse
);
  // ===========================================================
  // pin synchronisers
  logic [4:0] pins_s;                               // synchronised pins
  logic       sclk_s;                               // serial clock
  logic       sdin_s;                               // serial data
  logic       cs_n_s;                               // chip select
  logic       load_n_s;                             // load pin
  logic       clr_n_s;                              // clear pin
  // pins idle in their inactive state during reset, sclk low like the host
  odsc_sync #(
    .W    (5),
    .INIT (odsc_pkg::PIN_RST)
  ) u_sync (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .i_ce  (I_CE),
    .i_d   ({I_SCLK, I_SDIN, I_CS_N, I_OUTPUT_LOAD_N, I_HARD_CLEAR_N}),
    .o_q   (pins_s)
  );
  assign sclk_s   = pins_s[4];
  assign sdin_s   = pins_s[3];
  assign cs_n_s   = pins_s[2];
  assign load_n_s = pins_s[1];
  assign clr_n_s  = pins_s[0];
  // ===========================================================
  // edge detection
  logic sclk_q;                                     // last serial clock
  logic cs_n_q;                                     // last chip select
  logic sclk_fall;                                  // falling serial clock
  logic cs_fall;                                    // frame start
  logic cs_rise;                                    // frame end
  // history of the synchronised pins
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end
    else if (I_CE)
    begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
    end
  end
  assign sclk_fall = sclk_q & ~sclk_s;
  assign cs_fall   = cs_n_q & ~cs_n_s;
  assign cs_rise   = ~cs_n_q & cs_n_s;
  // ===========================================================
  // clear sources
  logic soft_clr;                                   // reset command
  logic any_clr;                                    // clear codes, power and sdout
  // pin, power-on and command all clear codes, power and sdout alike; only power-on clears the shifter
  assign any_clr = I_SYS_RST | ~clr_n_s | soft_clr;
  // ===========================================================
  // shift register and bit count
  logic [15:0]           shift_q;                   // serial word
  logic [4:0]            cnt_q;                     // bits seen, saturates
  logic                  in_frame_q;                // frame open
  logic                  shift_en;                  // take one bit
  // shift only inside a selected frame
  assign shift_en = in_frame_q & ~cs_n_s & sclk_fall;
  // frame tracking; a clear kills the frame in flight
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST || !clr_n_s)
      in_frame_q <= 1'b0;
    else if (I_CE)
    begin
      // clear pin aborts; restart needs a new select fall
      if (cs_fall)
        in_frame_q <= 1'b1;
      else if (cs_rise)
        in_frame_q <= 1'b0;
    end
  end
  // msb first, shifts toward the top
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      shift_q <= odsc_pkg::SHIFT_RST;
    else if (I_CE && shift_en)
      shift_q <= {shift_q[14:0], sdin_s};
  end
  // bit counter cleared at each frame start
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST || !clr_n_s)
      cnt_q <= '0;
    else if (I_CE)
    begin
      if (cs_fall)
        cnt_q <= '0;
      // saturate so longer frames keep the last sixteen
      else if (shift_en && cnt_q != odsc_pkg::CNT_FULL)
        cnt_q <= cnt_q + 5'h01;
    end
  end
  // ===========================================================
  // serial output
  // top bit leaves as new bit enters: 16-bit delay
  always_ff @(posedge I_CLK)
  begin
    if (any_clr)
      O_SDOUT <= 1'b0;
    else if (I_CE && shift_en)
      O_SDOUT <= shift_q[15];
  end
  // ===========================================================
  // command decode
  logic                  exec;                      // execute this cycle
  odsc_pkg::odsc_cmd_t   cmd;                       // command field
  logic [9:0]            code;                      // code field
  logic [7:0]            xmask;                     // transfer mask
  logic [7:0]            ld_in;                     // per-channel loads
  logic [7:0]            ld_out;                    // per-channel write-thru
  logic [7:0]            xfer;                      // per-channel transfer
  // execute only a complete word at deselect
  assign exec  = I_CE & in_frame_q & cs_rise & (cnt_q == odsc_pkg::CNT_FULL);
  assign cmd   = odsc_pkg::odsc_cmd_t'(shift_q[15:12]);
  // code passes on unchanged as straight binary
  assign code  = shift_q[11:2];
  assign xmask = shift_q[11:4];
  // pad bits are ignored; host keeps them zero
  // per-command channel strobes
  always_comb
  begin
    ld_in    = 8'h00;
    ld_out   = 8'h00;
    xfer     = 8'h00;
    soft_clr = 1'b0;
    if (exec)
    begin
      unique case (cmd)
        // no-op word leaves this device alone
        odsc_pkg::CMD_NOP    : ;
        odsc_pkg::CMD_RESET  : soft_clr = 1'b1;
        odsc_pkg::CMD_WT_LO  :
        begin
          ld_in  = 8'h0F;
          ld_out = 8'h0F;
        end
        odsc_pkg::CMD_WT_HI  :
        begin
          ld_in  = 8'hF0;
          ld_out = 8'hF0;
        end
        odsc_pkg::CMD_WT_ALL :
        begin
          ld_in  = 8'hFF;
          ld_out = 8'hFF;
        end
        odsc_pkg::CMD_IN_ALL : ld_in = 8'hFF;
        // bit 7 of mask is channel 8
        odsc_pkg::CMD_XFER   : xfer = xmask;
        // power command has no effect on this logic
        odsc_pkg::CMD_PWR    : ;
        // commands 2..9 select one input register
        default              :
          ld_in = 8'h01 << (shift_q[15:12] - 4'h2);
      endcase
    end
  end
  // ===========================================================
  // power state; clear powers all channels down
  always_ff @(posedge I_CLK)
  begin
    if (any_clr)
      O_POWERED <= odsc_pkg::PWR_RST;
    else if (I_CE)
      // any write-through or transfer powers the touched channel up
      O_POWERED <= O_POWERED | ld_out | xfer;
  end
  // executed-word strobe for monitoring
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_WORD_DONE <= 1'b0;
    else if (I_CE)
      O_WORD_DONE <= exec;
  end
  // ===========================================================
  // channel register pairs
  logic [9:0] in_reg [8];                           // input registers
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_ch
      // load pin low keeps outputs following inputs
      odsc_chreg u_ch (
        .i_clk    (I_CLK),
        .i_clr    (any_clr),
        .i_ce     (I_CE),
        .i_ld_in  (ld_in[g]),
        .i_ld_out (ld_out[g]),
        .i_xfer   (xfer[g]),
        .i_transp (~load_n_s),
        .i_code   (code),
        .o_in     (in_reg[g]),
        .o_out    (O_CODE[g*10 +: 10])
      );
    end
  endgenerate
  // ===========================================================
  // checks
  // short frame never executes
  short_frame_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (cs_rise && cnt_q != odsc_pkg::CNT_FULL) |=> !O_WORD_DONE)
    else $error("short frame executed");
  in_all_keep_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (exec && cmd == odsc_pkg::CMD_IN_ALL && load_n_s && clr_n_s)
      |=> $stable(O_CODE))
    else $error("load-all changed outputs");
  single_load_keep_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (exec && shift_q[15:12] inside {[4'h2:4'h9]} && load_n_s && clr_n_s)
      |=> $stable(O_CODE))
    else $error("single load changed outputs");
  // write through all updates every code
  wt_all_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (exec && cmd == odsc_pkg::CMD_WT_ALL && clr_n_s)
      |=> O_CODE == {8{$past(code)}})
    else $error("write-through all missed");
  // flagged channel one takes its input
  xfer_ch1_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (exec && cmd == odsc_pkg::CMD_XFER && xmask[0] && clr_n_s)
      |=> O_CODE[9:0] == $past(in_reg[0]))
    else $error("masked transfer missed");
  clear_pin_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (!clr_n_s && I_CE) |=> (O_CODE == '0 && O_POWERED == '0))
    else $error("clear left outputs");
  soft_clr_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    soft_clr |=> O_CODE == '0)
    else $error("reset command left outputs");
  shift_gate_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (!in_frame_q && I_CE) |=> $stable(shift_q))
    else $error("shift outside frame");
  // serial out carries bit from sixteen shifts earlier
  sdout_delay_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (shift_en && clr_n_s && !soft_clr && I_CE)
      |=> O_SDOUT == $past(shift_q[15]))
    else $error("serial out delay wrong");
  transp_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (!load_n_s && I_CE && !any_clr && ld_out == '0) |=>
      O_CODE[9:0] == $past(in_reg[0]))
    else $error("output not transparent");
endmodule // odsc_top
